/* File: verilog/tbc_consts.svh */
// register offsets, field positions, reset values and timing counts
`ifndef TBC_CONSTS_SVH
`define TBC_CONSTS_SVH

// register offsets
`define TBC_OFF_CONTROL    3'h0
`define TBC_OFF_COUNT_LOW  3'h1
`define TBC_OFF_COUNT_HIGH 3'h2
`define TBC_OFF_IRQ_STATUS 3'h3
`define TBC_OFF_IRQ_CLEAR  3'h4
`define TBC_OFF_IRQ_ENABLE 3'h5

// control field positions
`define TBC_BIT_COUNT_EN   0
`define TBC_BIT_CLK_SRC    1
`define TBC_BIT_SYNC_BYP   2
`define TBC_BIT_OSC_EN     3
`define TBC_BIT_SYS_OSC    6
`define TBC_BIT_WIDE       7

// interrupt bit positions
`define TBC_IRQ_OVERFLOW   0

// reset values
`define TBC_RST_CONTROL    8'h00
`define TBC_RST_COUNT      16'h0000
`define TBC_RST_IRQ        8'h00

// count limits and trigger code
`define TBC_COUNT_MAX      16'hFFFF
`define TBC_TRIG_MODE      4'hB

// instruction cycle is the system clock divided by this
`define TBC_INSTR_DIV      4

`endif

/* File: verilog/tbc_pkg.sv */
// types shared by the timer/counter block
package tbc_pkg;

    // control register layout, bit 7 down to bit 0
    typedef struct packed {
        logic       wideAccessMode;
        logic       systemClockFromLowPowerOsc;
        logic [1:0] inputPrescaleSelect;
        logic       crystalOscillatorEnable;
        logic       externalSyncBypass;
        logic       clockSourceSelect;
        logic       countEnable;
    } tbc_control_type;

    // register bus request
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wrData;
        logic       write;
        logic       read;
    } tbc_bus_req_type;

    // count source mode
    typedef enum logic [1:0] {
        TBC_MODE_TIMER,
        TBC_MODE_SYNC,
        TBC_MODE_ASYNC
    } tbc_mode_type;

endpackage

/* File: verilog/tbc_timer_counter.sv */
// sixteen-bit timer/counter with prescaler, crystal source and overflow interrupt
//
// The address map and strobed register access were chosen for this implementation.
`timescale 1ns/10ps
`include "tbc_consts.svh"

module tbc_timer_counter (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_b,
    // register port
    input  wire logic [2:0] regAddr,
    input  wire logic [7:0] regWrData,
    input  wire logic       regWrite,
    input  wire logic       regRead,
    output logic      [7:0] regRdData,
    // pins
    input  wire logic       extCountIn,
    input  wire logic       crystalIn,
    input  wire logic [1:0] portPinIn,
    output logic      [1:0] portPinRead,
    output logic            pinDigitalEnable,
    output logic            crystalOscEnable,
    // system
    input  wire logic       sysClkFromOsc,
    input  wire logic       sleepMode,
    input  wire logic [3:0] compareMode,
    input  wire logic       compareEvent,
    // results
    output logic     [15:0] countValue,
    output logic            irq
);

    // ****************************************************
    // declarations
    // ****************************************************
    localparam int SYNC_W = 5;

    tbc_pkg::tbc_bus_req_type  busReq;
    tbc_pkg::tbc_control_type  control;
    tbc_pkg::tbc_mode_type     mode;

    logic [SYNC_W-1:0] syncStage1;
    logic [SYNC_W-1:0] syncStage2;
    logic [1:0]        instrDiv;
    logic              instrTick;
    logic              srcLevel;
    logic              prevSrc;
    logic              riseEdge;
    logic              fallEdge;
    logic              armed;
    logic              pending;
    logic              active;
    logic              rawEdge;
    logic [2:0]        prescale;
    logic [2:0]        prescaleMask;
    logic              countTick;
    logic [15:0]       count;
    logic [7:0]        highBuffer;
    logic              wrLow;
    logic              wrHigh;
    logic              rdLow;
    logic              countWrite;
    logic              trigger;
    logic              overflowEvent;
    logic [7:0]        irqStatus;
    logic [7:0]        irqEnable;
    logic [7:0]        irqClear;
    logic [7:0]        next_rdData;

    // ****************************************************
    // decoding helpers
    // ****************************************************
    function automatic logic [2:0] maskOf(input logic [1:0] sel);
        logic [2:0] m;
        m = 3'h0;
        unique case (sel)
            2'h0: m = 3'h0;
            2'h1: m = 3'h1;
            2'h2: m = 3'h3;
            2'h3: m = 3'h7;
        endcase
        return m;
    endfunction

    assign busReq = '{addr: regAddr, wrData: regWrData,
                      write: regWrite, read: regRead};

    assign wrLow      = busReq.write && busReq.addr == `TBC_OFF_COUNT_LOW;
    assign wrHigh     = busReq.write && busReq.addr == `TBC_OFF_COUNT_HIGH;
    assign rdLow      = busReq.read && busReq.addr == `TBC_OFF_COUNT_LOW;
    assign countWrite = wrLow || (wrHigh && !control.wideAccessMode);
    assign irqClear   = (busReq.write && busReq.addr == `TBC_OFF_IRQ_CLEAR)
                        ? busReq.wrData : 8'h00;

    // ****************************************************
    // pin synchroniser
    // ****************************************************
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            syncStage1 <= '0;
            syncStage2 <= '0;
        end else begin
            syncStage1 <= {sysClkFromOsc, portPinIn, crystalIn, extCountIn};
            syncStage2 <= syncStage1;
        end
    end

    // ****************************************************
    // crystal oscillator and pins
    // ****************************************************
    assign crystalOscEnable = control.crystalOscillatorEnable;
    assign pinDigitalEnable = !control.crystalOscillatorEnable;
    assign portPinRead = control.crystalOscillatorEnable ? 2'h0 : syncStage2[3:2];

    // ****************************************************
    // source selection and edges
    // ****************************************************
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            instrDiv <= 2'h0;
        end else begin
            instrDiv <= instrDiv + 2'h1;
        end
    end

    assign instrTick = instrDiv == 2'(`TBC_INSTR_DIV - 1);

    assign srcLevel = control.crystalOscillatorEnable ? syncStage2[1] : syncStage2[0];
    assign riseEdge = srcLevel && !prevSrc;
    assign fallEdge = !srcLevel && prevSrc;

    always_comb begin
        if (!control.clockSourceSelect) begin
            mode = tbc_pkg::TBC_MODE_TIMER;
        end else if (control.externalSyncBypass) begin
            mode = tbc_pkg::TBC_MODE_ASYNC;
        end else begin
            mode = tbc_pkg::TBC_MODE_SYNC;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prevSrc <= 1'b0;
        end else begin
            prevSrc <= srcLevel;
        end
    end

    // falling edge must be seen before the first counted rising edge
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            armed <= 1'b0;
        end else if (countWrite || wrHigh) begin
            armed <= 1'b0;
        end else if (fallEdge && control.countEnable) begin
            // a fall seen while stopped does not arm the next start
            armed <= 1'b1;
        end else if (!control.countEnable && srcLevel) begin
            armed <= 1'b0;
        end
    end

    // synchronised edges wait for the next instruction cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pending <= 1'b0;
        end else if (riseEdge && armed) begin
            pending <= 1'b1;
        end else if (instrTick || mode != tbc_pkg::TBC_MODE_SYNC) begin
            pending <= 1'b0;
        end
    end

    // ****************************************************
    // prescaler and count enable
    // ****************************************************
    assign active = control.countEnable
                    && !(sleepMode && mode != tbc_pkg::TBC_MODE_ASYNC);

    always_comb begin
        unique case (mode)
            tbc_pkg::TBC_MODE_TIMER: rawEdge = instrTick;
            tbc_pkg::TBC_MODE_SYNC:  rawEdge = pending && instrTick;
            tbc_pkg::TBC_MODE_ASYNC: rawEdge = riseEdge && armed;
            default:                 rawEdge = 1'b0;
        endcase
    end

    assign prescaleMask = maskOf(control.inputPrescaleSelect);
    assign countTick = active && rawEdge && ((prescale & prescaleMask) == prescaleMask);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prescale <= 3'h0;
        end else if (wrLow || wrHigh) begin
            prescale <= 3'h0;
        end else if (active && rawEdge) begin
            prescale <= countTick ? 3'h0 : prescale + 3'h1;
        end
    end

    // ****************************************************
    // count and high byte buffer
    // ****************************************************
    assign trigger = compareEvent && compareMode == `TBC_TRIG_MODE
                     && mode != tbc_pkg::TBC_MODE_ASYNC;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count <= `TBC_RST_COUNT;
        end else if (wrLow) begin
            if (control.wideAccessMode) begin
                count <= {highBuffer, busReq.wrData};
            end else begin
                count[7:0] <= busReq.wrData;
            end
        end else if (wrHigh && !control.wideAccessMode) begin
            count[15:8] <= busReq.wrData;
        end else if (trigger) begin
            count <= `TBC_RST_COUNT;
        end else if (countTick) begin
            count <= count + 16'h0001;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            highBuffer <= 8'h00;
        end else if (wrHigh && control.wideAccessMode) begin
            highBuffer <= busReq.wrData;
        end else if (rdLow && control.wideAccessMode) begin
            highBuffer <= count[15:8];
        end
    end

    assign countValue = count;
    assign overflowEvent = countTick && count == `TBC_COUNT_MAX
                           && !countWrite && !trigger;

    // ****************************************************
    // control register
    // ****************************************************
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            control <= `TBC_RST_CONTROL;
        end else if (busReq.write && busReq.addr == `TBC_OFF_CONTROL) begin
            control <= busReq.wrData;
            control.systemClockFromLowPowerOsc <= 1'b0;
        end
    end

    // ****************************************************
    // interrupts
    // ****************************************************
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irqStatus <= `TBC_RST_IRQ;
        end else begin
            irqStatus <= (irqStatus & ~irqClear)
                         | (8'(overflowEvent) << `TBC_IRQ_OVERFLOW);
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irqEnable <= `TBC_RST_IRQ;
        end else if (busReq.write && busReq.addr == `TBC_OFF_IRQ_ENABLE) begin
            irqEnable <= busReq.wrData;
        end
    end

    assign irq = |(irqStatus & irqEnable);

    // ****************************************************
    // read data
    // ****************************************************
    always_comb begin
        next_rdData = 8'h00;
        if (busReq.read) begin
            unique case (busReq.addr)
                `TBC_OFF_CONTROL: begin
                    next_rdData = control;
                    next_rdData[`TBC_BIT_SYS_OSC] = syncStage2[4];
                end
                `TBC_OFF_COUNT_LOW:  next_rdData = count[7:0];
                `TBC_OFF_COUNT_HIGH: next_rdData = control.wideAccessMode
                                     ? highBuffer : count[15:8];
                `TBC_OFF_IRQ_STATUS: next_rdData = irqStatus;
                `TBC_OFF_IRQ_ENABLE: next_rdData = irqEnable;
                default:             next_rdData = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            regRdData <= 8'h00;
        end else begin
            regRdData <= next_rdData;
        end
    end

endmodule

/* File: verif/tbc_timer_counter_properties.sv */
// concurrent checks on the timer/counter ports
`timescale 1ns/10ps
`include "tbc_consts.svh"
module tbc_timer_counter_properties (
    // clock and reset
    input wire logic        clk,
    input wire logic        rst_b,
    // register port
    input wire logic [2:0]  regAddr,
    input wire logic [7:0]  regWrData,
    input wire logic        regWrite,
    input wire logic        regRead,
    input wire logic [7:0]  regRdData,
    // pins and system
    input wire logic [1:0]  portPinIn,
    input wire logic [1:0]  portPinRead,
    input wire logic        pinDigitalEnable,
    input wire logic        crystalOscEnable,
    input wire logic [3:0]  compareMode,
    input wire logic        compareEvent,
    // results
    input wire logic [15:0] countValue,
    input wire logic        irq
);
    //****
    // register shadows
    //****
    logic [7:0] ctrl;
    logic       irqEn;
    logic       quiet;
    assign quiet = !regWrite && !compareEvent;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl <= 8'h00;
        end else if (regWrite && regAddr == `TBC_OFF_CONTROL) begin
            ctrl <= regWrData;
        end
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irqEn <= 1'b0;
        end else if (regWrite && regAddr == `TBC_OFF_IRQ_ENABLE) begin
            irqEn <= regWrData[0];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence s_inc;
        countValue == $past(countValue) + 16'h0001;
    endsequence
    sequence s_wrap;
        countValue == 16'hFFFF && quiet ##1 countValue == 16'h0000;
    endsequence
    a_read_idle: assert property (!$past(regRead) |-> regRdData == 8'h00)
        else $error("read data outside slot");
    a_hold_off: assert property (!ctrl[0] && quiet |=> $stable(countValue))
        else $error("count moved while off");
    a_timer_step: assert property (
        s_inc ##0 (!ctrl[1] && quiet) ##1 quiet[*2] |=> countValue == $past(countValue, 3))
        else $error("timer steps too close");
    a_trig_clear: assert property (
        compareEvent && compareMode == 4'hB && !regWrite && !(ctrl[1] && ctrl[2])
        |=> countValue == 16'h0000) else $error("trigger missed");
    a_write_wins: assert property (
        compareEvent && regWrite && regAddr == 3'h1 && !ctrl[7]
        |=> countValue[7:0] == $past(regWrData)) else $error("write lost");
    a_osc_power: assert property (
        crystalOscEnable == ctrl[3] && pinDigitalEnable == !ctrl[3]) else $error("osc");
    a_pins_zero: assert property (
        crystalOscEnable |-> portPinRead == 2'b00) else $error("pins not zero");
    a_pins_follow: assert property (
        !crystalOscEnable |-> portPinRead == $past(portPinIn, 2)) else $error("pins not passed");
    a_wrap_flag: assert property (s_wrap ##0 irqEn |-> ##[0:1] irq)
        else $error("no overflow irq");
    a_irq_masked: assert property (!irqEn |-> !irq)
        else $error("masked irq");
endmodule

/* File: verif/tbc_count_source.sv */
// far-side model: external count pin and crystal oscillator
`timescale 1ns/10ps
module tbc_count_source (
    // clock and control
    input wire logic clk,
    input wire logic run,
    input wire logic oscOn,
    // pins
    output logic     extCountIn,
    output logic     crystalIn
);
    logic [1:0] phase = 2'h0;
    logic [3:0] oscDiv = 4'h0;
    initial extCountIn = 1'b0;
    initial crystalIn = 1'b0;
    // pin idles low, so each burst starts with a rise
    always @(posedge clk) begin
        if (!run) begin
            phase <= 2'h0;
            extCountIn <= 1'b0;
        end else begin
            phase <= phase + 2'h1;
            if (phase == 2'h3) begin
                extCountIn <= !extCountIn;
            end
        end
    end
    // oscillator output stands still while unpowered
    always @(posedge clk) begin
        oscDiv <= oscDiv + 4'h1;
        crystalIn <= oscOn & oscDiv[3];
    end
endmodule

/* File: verif/tbc_timer_counter_bench.sv */
// self-checking bench for the timer/counter
`timescale 1ns/10ps
module tbc_timer_counter_bench;
    logic        clk = 1'b0, rst_b = 1'b0, regWrite = 1'b0, regRead = 1'b0;
    logic [2:0]  regAddr = 3'h0;
    logic [7:0]  regWrData = 8'h00, regRdData;
    logic [1:0]  portPinIn = 2'h0, portPinRead;
    logic        sysClkFromOsc = 1'b0, sleepMode = 1'b0, compareEvent = 1'b0, run = 1'b0;
    logic [3:0]  compareMode = 4'h0;
    logic [15:0] countValue;
    logic        extCountIn, crystalIn, crystalOscEnable, pinDigitalEnable, irq, rdPend;
    logic [31:0] seed = 32'h5D62;
    logic [8:0]  notes[$];
    logic [8:0]  note;
    int          errors = 0, checked = 0;
    always #4 clk = !clk;
    tbc_timer_counter u_tbc_timer_counter (.clk, .rst_b, .regAddr, .regWrData, .regWrite,
        .regRead, .regRdData, .extCountIn, .crystalIn, .portPinIn, .portPinRead,
        .pinDigitalEnable, .crystalOscEnable, .sysClkFromOsc, .sleepMode, .compareMode,
        .compareEvent, .countValue, .irq);
    tbc_count_source u_tbc_count_source (.clk, .run, .oscOn(crystalOscEnable), .extCountIn,
        .crystalIn);
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        return v ^ (v << 5);
    endfunction
    task automatic wr(input logic [2:0] a, input logic [7:0] d, input logic c = 1'b0);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        compareEvent <= c;
        @(posedge clk);
        regWrite <= 1'b0;
        compareEvent <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic t = 1'b0);
        regAddr <= a;
        regRead <= 1'b1;
        notes.push_back({t, e});
        @(posedge clk);
        regRead <= 1'b0;
        @(posedge clk);
    endtask
    //****
    // result watcher: oldest note against read data
    //****
    always @(posedge clk) begin
        rdPend <= regRead;
        if (rdPend === 1'b1) begin
            note = notes.pop_front();
            checked++;
            if (!(regRdData === note[7:0] || note[8] && (regRdData === note[7:0] + 8'h01
                || regRdData === note[7:0] - 8'h01))) begin
                errors++;
                $display("wrong value at %0t: got %h want %h", $time, regRdData, note[7:0]);
            end
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        seed = xs(seed);
        portPinIn <= seed[17:16];
        @(posedge clk);
        for (int a = 0; a < 8; a++) begin
            rd(a[2:0], 8'h00);
        end
        wr(3'h0, 8'h40);
        wr(3'h7, 8'hFF);
        rd(3'h0, 8'h00);
        rd(3'h7, 8'h00);
        wr(3'h1, seed[7:0]);
        wr(3'h2, seed[15:8]);
        rd(3'h1, seed[7:0]);
        wr(3'h0, 8'h80);
        wr(3'h2, 8'hC3);
        rd(3'h1, seed[7:0]);
        rd(3'h2, seed[15:8]);
        wr(3'h2, 8'h3C);
        wr(3'h1, 8'hA5);
        rd(3'h1, 8'hA5);
        wr(3'h0, 8'h00);
        rd(3'h2, 8'h3C);
        for (int p = 0; p < 4; p++) begin
            wr(3'h1, 8'h00);
            wr(3'h2, 8'h00);
            wr(3'h0, {2'h0, p[1:0], 4'h1});
            repeat (255) @(posedge clk);
            wr(3'h0, {2'h0, p[1:0], 4'h0});
            rd(3'h1, 8'h40 >> p, 1'b1);
        end
        for (int m = 0; m < 4; m++) begin
            sleepMode <= m[1];
            wr(3'h1, 8'h00);
            wr(3'h0, m[0] ? 8'h03 : 8'h07);
            run <= 1'b1;
            repeat (80) @(posedge clk);
            run <= 1'b0;
            repeat (10) @(posedge clk);
            wr(3'h0, 8'h00);
            rd(3'h1, (m == 3) ? 8'h00 : 8'h09);
        end
        sleepMode <= 1'b0;
        wr(3'h5, 8'h01);
        wr(3'h1, 8'hFE);
        wr(3'h2, 8'hFF);
        wr(3'h0, 8'h01);
        repeat (16) @(posedge clk);
        wr(3'h0, 8'h00);
        rd(3'h3, 8'h01);
        rd(3'h2, 8'h00);
        wr(3'h5, 8'h00);
        wr(3'h4, 8'h01);
        rd(3'h3, 8'h00);
        compareMode <= 4'hB;
        wr(3'h1, 8'h5A, 1'b1);
        rd(3'h1, 8'h5A);
        wr(3'h2, 8'h40);
        wr(3'h0, 8'h31);
        compareEvent <= 1'b1;
        @(posedge clk);
        wr(3'h0, 8'h30);
        rd(3'h2, 8'h00);
        sysClkFromOsc <= 1'b1;
        wr(3'h0, 8'h08);
        rd(3'h0, 8'h48);
        @(posedge clk);
        print_verdict;
    end
    initial begin
        repeat (10000) @(posedge clk);
        errors++;
        print_verdict;
    end
    task automatic print_verdict;
        if (errors == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
endmodule
bind tbc_timer_counter tbc_timer_counter_properties u_tbc_timer_counter_properties (
    .clk, .rst_b, .regAddr, .regWrData, .regWrite, .regRead, .regRdData, .portPinIn, .portPinRead,
    .pinDigitalEnable, .crystalOscEnable, .compareMode, .compareEvent, .countValue, .irq);
